// >>> sram_host_pkg.sv
package sram_host_pkg;
	localparam int ADDR_W          = 8;
	localparam int DATA_W          = 4;
	localparam int WORDS           = 256;
	localparam int TOTAL_BITS      = 1024;
	localparam int CLK_PERIOD_NS   = 10;
	// standard-grade worst case figures, in ns
	localparam int ADDR_SETUP_NS   = 10;
	localparam int WRITE_PULSE_NS  = 40;
	localparam int ADDR_HOLD_NS    = 10;
	localparam int DATA_HOLD_NS    = 5;
	localparam int SELECT_HOLD_NS  = 10;
	localparam int WRITE_REC_NS    = 50;
	localparam int ACCESS_NS       = 60;
	localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int HOLD_NS_MAX     = (ADDR_HOLD_NS > SELECT_HOLD_NS)
		? ADDR_HOLD_NS : SELECT_HOLD_NS;
	localparam int HOLD_CYC        = (HOLD_NS_MAX + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WRITE_REC_CYC   = (WRITE_REC_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CNT_W           = 4;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_PULSE = 3'b010,
		ST_HOLD  = 3'b011,
		ST_READ  = 3'b100,
		ST_REC   = 3'b101
	} phase_e;
endpackage

// >>> sram_phase_timer.sv
`timescale 1ns/100ps
// counts down a phase length; done pulses on the last cycle
module sram_phase_timer #(
	parameter int CNT_W = 4
) (
	input  wire logic             ref_clk_i,
	input  wire logic             resetn_i,
	input  wire logic             load_i,
	input  wire logic [CNT_W-1:0] len_i,
	output logic                  done_o
);
	logic [CNT_W-1:0] count;

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			count <= '0;
		end else if (load_i) begin
			count <= len_i;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	// plain count compare; gating with load would close a loop through
	// the phase logic, which reloads on done
	assign done_o = (count == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

// >>> sram_host_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - host holds write data stable through setup, pulse and hold
// - host keeps write enable low at least the minimum pulse width
// - host sets address before write enable and holds it until release
// - larger arrays decode chip selects from upper address bits
module sram_host_ctrl #(
	parameter int ADDR_W = sram_host_pkg::ADDR_W,
	parameter int DATA_W = sram_host_pkg::DATA_W,
	parameter int BANK_W = 1
) (
	input  wire logic                     ref_clk_i,
	input  wire logic                     resetn_i,
	input  wire logic                     req_valid_i,
	input  wire logic                     req_write_i,
	input  wire logic [BANK_W+ADDR_W-1:0] req_addr_i,
	input  wire logic [DATA_W-1:0]        req_wdata_i,
	output logic                          req_ready_o,
	output logic                          rsp_valid_o,
	output logic [DATA_W-1:0]             rsp_rdata_o,
	output logic [ADDR_W-1:0]             word_select_lines_o,
	output logic [DATA_W-1:0]             write_data_in_o,
	input  wire logic [DATA_W-1:0]        read_data_out_i,
	output logic [(1<<BANK_W)-1:0]        select_low_active_n_o,
	output logic [(1<<BANK_W)-1:0]        select_high_active_o,
	output logic                          write_enable_n_o,
	output logic                          output_enable_n_o
);
	localparam int NB = 1 << BANK_W;
	localparam logic [sram_host_pkg::CNT_W-1:0] SETUP_LEN =
		sram_host_pkg::CNT_W'(sram_host_pkg::ADDR_SETUP_CYC);
	localparam logic [sram_host_pkg::CNT_W-1:0] PULSE_LEN =
		sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_PULSE_CYC);
	localparam logic [sram_host_pkg::CNT_W-1:0] HOLD_LEN =
		sram_host_pkg::CNT_W'(sram_host_pkg::HOLD_CYC);
	localparam logic [sram_host_pkg::CNT_W-1:0] READ_LEN =
		sram_host_pkg::CNT_W'(sram_host_pkg::ACCESS_CYC + 1);
	localparam logic [sram_host_pkg::CNT_W-1:0] REC_LEN =
		sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_REC_CYC);

	sram_host_pkg::phase_e state;
	sram_host_pkg::phase_e next_state;
	logic                                  timer_load;
	logic [sram_host_pkg::CNT_W-1:0]       timer_len;
	logic                                  timer_done;
	logic [BANK_W-1:0]                     bank;
	logic [BANK_W-1:0]                     next_bank;
	logic                                  accept;
	logic                                  read_done;

	assign accept = req_ready_o && req_valid_i;

	// a new request's bank counts in the cycle it is taken
	assign next_bank = accept ? req_addr_i[BANK_W+ADDR_W-1:ADDR_W] : bank;

	// last cycle of the access window: device outputs have settled
	assign read_done = (state == sram_host_pkg::ST_READ) && timer_done;

	sram_phase_timer #(
		.CNT_W (sram_host_pkg::CNT_W)
	) u_timer (
		.ref_clk_i (ref_clk_i),
		.resetn_i  (resetn_i),
		.load_i    (timer_load),
		.len_i     (timer_len),
		.done_o    (timer_done)
	);

	// write runs setup, pulse, hold, recovery; read is one access window
	always_comb begin
		next_state = state;
		timer_load = 1'b0;
		timer_len  = SETUP_LEN;
		case (state)
			sram_host_pkg::ST_IDLE: begin
				if (accept) begin
					timer_load = 1'b1;
					if (req_write_i) begin
						next_state = sram_host_pkg::ST_SETUP;
						timer_len  = SETUP_LEN;
					end else begin
						next_state = sram_host_pkg::ST_READ;
						timer_len  = READ_LEN;
					end
				end
			end
			sram_host_pkg::ST_SETUP: begin
				if (timer_done) begin
					next_state = sram_host_pkg::ST_PULSE;
					timer_load = 1'b1;
					timer_len  = PULSE_LEN;
				end
			end
			sram_host_pkg::ST_PULSE: begin
				if (timer_done) begin
					next_state = sram_host_pkg::ST_HOLD;
					timer_load = 1'b1;
					timer_len  = HOLD_LEN;
				end
			end
			sram_host_pkg::ST_HOLD: begin
				if (timer_done) begin
					next_state = sram_host_pkg::ST_REC;
					timer_load = 1'b1;
					timer_len  = REC_LEN;
				end
			end
			sram_host_pkg::ST_READ: begin
				if (timer_done) begin
					next_state = sram_host_pkg::ST_IDLE;
				end
			end
			sram_host_pkg::ST_REC: begin
				if (timer_done) begin
					next_state = sram_host_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = sram_host_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state <= sram_host_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ready rises as the phases return to idle; nothing is taken earlier
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			req_ready_o <= 1'b0;
		end else begin
			req_ready_o <= (next_state == sram_host_pkg::ST_IDLE);
		end
	end

	// address and data latched once and held until the next request
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			word_select_lines_o <= '0;
			write_data_in_o     <= '0;
		end else if (accept) begin
			word_select_lines_o <= req_addr_i[ADDR_W-1:0];
			write_data_in_o     <= req_wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			bank <= '0;
		end else begin
			bank <= next_bank;
		end
	end

	// selects decoded from upper request address bits, one pair per bank;
	// taken from the next phase so they lead and trail write enable by a
	// cycle, covering select setup and hold around the pulse
	genvar b;
	generate
		for (b = 0; b < NB; b++) begin : g_bank
			logic sel;
			assign sel = (next_bank == BANK_W'(b))
				&& (next_state != sram_host_pkg::ST_IDLE)
				&& (next_state != sram_host_pkg::ST_REC);
			always_ff @(posedge ref_clk_i) begin
				if (!resetn_i) begin
					select_low_active_n_o[b] <= 1'b1;
					select_high_active_o[b]  <= 1'b0;
				end else begin
					select_low_active_n_o[b] <= !sel;
					select_high_active_o[b]  <= sel;
				end
			end
		end
	endgenerate

	// write enable low only in the pulse phase, framed by setup and hold
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			write_enable_n_o <= 1'b1;
		end else begin
			write_enable_n_o <= !(next_state == sram_host_pkg::ST_PULSE);
		end
	end

	// output enable only on reads, so device outputs float on writes
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			output_enable_n_o <= 1'b1;
		end else begin
			output_enable_n_o <= !(next_state == sram_host_pkg::ST_READ);
		end
	end

	// one-cycle answer strobe at the end of the access window
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rsp_valid_o <= 1'b0;
		end else begin
			rsp_valid_o <= read_done;
		end
	end

	// read data sampled once the access delay has elapsed, held until the
	// next read answer
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rsp_rdata_o <= '0;
		end else if (read_done) begin
			rsp_rdata_o <= read_data_out_i;
		end
	end
endmodule

// >>> sram_dev_model.sv
`timescale 1ns/100ps
// behavioural 256x4 memory; floating outputs show the inverse of the last word
module sram_dev_model (
	input  wire logic [7:0]	word_select_lines_i,
	input  wire logic [3:0]	write_data_in_i,
	input  wire logic	select_low_active_n_i,
	input  wire logic	select_high_active_i,
	input  wire logic	write_enable_n_i,
	input  wire logic	output_enable_n_i,
	output logic [3:0]	read_data_out_o
);
	logic [3:0]	mem [256];
	logic [3:0]	last = 4'h0;
	wire	sel = !select_low_active_n_i && select_high_active_i;
	wire	rd = sel && write_enable_n_i && !output_enable_n_i;
	always @* begin
		if (sel && !write_enable_n_i)
			mem[word_select_lines_i] = write_data_in_i;
	end
	// tracks the addressed word while reading, keeps it once released
	always @* begin
		if (rd)
			last = mem[word_select_lines_i];
	end
	assign read_data_out_o = rd ? last : ~last;
endmodule

// >>> sram_host_ctrl_monitor.sv
`timescale 1ns/100ps
module sram_host_ctrl_monitor #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 4,
	parameter int BANK_W = 1
) (
	input wire logic	ref_clk_i,
	input wire logic	resetn_i,
	input wire logic	req_valid_i,
	input wire logic	req_write_i,
	input wire logic [BANK_W+ADDR_W-1:0]	req_addr_i,
	input wire logic [DATA_W-1:0]	req_wdata_i,
	input wire logic	req_ready_o,
	input wire logic	rsp_valid_o,
	input wire logic [DATA_W-1:0]	rsp_rdata_o,
	input wire logic [ADDR_W-1:0]	word_select_lines_o,
	input wire logic [DATA_W-1:0]	write_data_in_o,
	input wire logic [DATA_W-1:0]	read_data_out_i,
	input wire logic [(1<<BANK_W)-1:0]	select_low_active_n_o,
	input wire logic [(1<<BANK_W)-1:0]	select_high_active_o,
	input wire logic	write_enable_n_o,
	input wire logic	output_enable_n_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	pulse_width_a: assert property ($fell(write_enable_n_o) |->
		!write_enable_n_o[*4] ##1 write_enable_n_o) else $error("bad pulse");
	addr_stable_a: assert property (!write_enable_n_o |->
		$stable(word_select_lines_o)) else $error("address moved");
	data_stable_a: assert property (!write_enable_n_o |->
		$stable(write_data_in_o)) else $error("data moved");
	write_hold_a: assert property ($past(resetn_i) &&
		$rose(write_enable_n_o) |->
		$stable(write_data_in_o) && $stable(word_select_lines_o))
		else $error("hold too short");
	oe_excl_a: assert property (
		!write_enable_n_o |-> output_enable_n_o)
		else $error("oe low in write");
	bank_sel_a: assert property (
		(!write_enable_n_o || !output_enable_n_o) |->
		$onehot(~select_low_active_n_o) &&
		select_high_active_o == ~select_low_active_n_o) else $error("bad sel");
	read_lat_a: assert property (
		$fell(output_enable_n_o) |-> ##7 rsp_valid_o)
		else $error("read late");
	cover property ($fell(write_enable_n_o));
	cover property (rsp_valid_o);
	cover property (!select_low_active_n_o[1]);
endmodule

// >>> sram_host_ctrl_tb.sv
`timescale 1ns/100ps
module sram_host_ctrl_tb;
	logic	ref_clk_i = 1'b0, resetn_i = 1'b0, req_valid_i = 1'b0;
	logic	req_write_i = 1'b0, ready, rv, we_n, oe_n;
	logic [8:0]	req_addr_i = 9'h000;
	logic [3:0]	req_wdata_i = 4'h0, rdata, wd, r, q [2];
	logic [7:0]	wa;
	logic [1:0]	sl_n, sh;
	logic [17:0]	rows [12] = '{18'h200A0, 18'h30050, 18'h2FFF0,
		18'h3FF00, 18'h2AA60, 18'h0000A, 18'h10005, 18'h0FF0F,
		18'h1FF00, 18'h0AA06, 18'h20030, 18'h00003};
	int	fails = 0, n_checks = 0, i;
	sram_host_ctrl dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.req_valid_i(req_valid_i), .req_write_i(req_write_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
		.req_ready_o(ready), .rsp_valid_o(rv), .rsp_rdata_o(rdata),
		.word_select_lines_o(wa), .write_data_in_o(wd),
		.read_data_out_i(sl_n[1] ? q[0] : q[1]),
		.select_low_active_n_o(sl_n), .select_high_active_o(sh),
		.write_enable_n_o(we_n), .output_enable_n_o(oe_n));
	for (genvar b = 0; b < 2; b++) begin : g_bank
		sram_dev_model m (.word_select_lines_i(wa), .write_data_in_i(wd),
			.select_low_active_n_i(sl_n[b]), .select_high_active_i(sh[b]),
			.write_enable_n_i(we_n), .output_enable_n_i(oe_n),
			.read_data_out_o(q[b]));
	end
	task automatic check(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic guard;
		if (i >= 40) begin
			fails++;
			final_report();
		end
	endtask
	task automatic req(input logic w, input logic [8:0] a,
		input logic [3:0] d);
		@(negedge ref_clk_i);
		req_valid_i = 1'b1;
		req_write_i = w;
		req_addr_i = a;
		req_wdata_i = d;
		for (i = 0; i < 40 && ready !== 1'b1; i++) @(negedge ref_clk_i);
		guard();
		@(negedge ref_clk_i);
		req_valid_i = 1'b0;
		for (i = 0; i < 40 && !w && rv !== 1'b1; i++) @(negedge ref_clk_i);
		guard();
		r = rdata;
	endtask
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		repeat (5) @(negedge ref_clk_i);
		check({ready, rv, we_n, oe_n}, 4'h3);
		check({sl_n, sh}, 4'hC);
		resetn_i = 1'b1;
		foreach (rows[k]) begin
			req(rows[k][17], rows[k][16:8], rows[k][7:4]);
			if (!rows[k][17])
				check(r, rows[k][3:0]);
		end
		// reset in the middle of a write pulse
		@(negedge ref_clk_i);
		req_valid_i = 1'b1;
		req_write_i = 1'b1;
		req_addr_i = 9'h033;
		req_wdata_i = 4'h9;
		repeat (4) @(negedge ref_clk_i);
		check({we_n, oe_n, sl_n[0], sh[0]}, 4'h5);
		check(wa[7:4], 4'h3);
		check(wa[3:0], 4'h3);
		check(wd, 4'h9);
		resetn_i = 1'b0;
		req_valid_i = 1'b0;
		@(negedge ref_clk_i);
		check({ready, rv, we_n, oe_n}, 4'h3);
		check({sl_n, sh}, 4'hC);
		resetn_i = 1'b1;
		req(1'b0, 9'h000, 4'h0);
		check(r, 4'h3);
		final_report();
	end
endmodule
bind sram_host_ctrl sram_host_ctrl_monitor #(.ADDR_W(ADDR_W),
	.DATA_W(DATA_W), .BANK_W(BANK_W)) u_mon (.ref_clk_i(ref_clk_i),
	.resetn_i(resetn_i), .req_valid_i(req_valid_i),
	.req_write_i(req_write_i), .req_addr_i(req_addr_i),
	.req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
	.rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
	.word_select_lines_o(word_select_lines_o),
	.write_data_in_o(write_data_in_o),
	.read_data_out_i(read_data_out_i),
	.select_low_active_n_o(select_low_active_n_o),
	.select_high_active_o(select_high_active_o),
	.write_enable_n_o(write_enable_n_o),
	.output_enable_n_o(output_enable_n_o));
